// ===== verilog/smh_device.sv
// Add-in module end: control register, window decode, timer and memory.
`timescale 1ns/100ps
module smh_device (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Host link
  smh_link_if.dev          link,
  // Internal processor control
  input  wire logic        fw_state_wr_i,
  input  wire logic [3:0]  fw_state_i,
  input  wire logic        host_alert_set_i,
  input  wire logic        module_alert_ack_i,
  input  wire logic        tick_period_wr_i,
  input  wire logic [15:0] tick_period_i,
  output logic             module_alert_irq_o,
  output logic             cpu_reset_o,
  output logic             dsp_reset_o,
  output logic             line_reset_o,
  // Internal processor memory port
  input  wire logic [14:0] mod_mem_addr_i,
  input  wire logic        mod_mem_we_i,
  input  wire logic [15:0] mod_mem_wdata_i,
  output logic [15:0]      mod_mem_rdata_o,
  // Private ring pointers
  input  wire logic        mod_ptr_wr_i,
  input  wire logic        mod_ptr_sel_i,
  input  wire logic [15:0] mod_ptr_i,
  output logic [15:0]      mod_load_ptr_o,
  output logic [15:0]      mod_unload_ptr_o
);
  logic        hard_rst;
  logic        core_rst_reg;
  logic [3:0]  state_reg;
  logic        hold_reg;
  logic        win_en_reg;
  logic        irq_en_reg;
  logic        db_host_reg;
  logic [5:0]  bank_reg;
  logic        tick_en_reg;
  logic        db_mod_reg;
  logic [15:0] csr_word;
  logic        new_req;
  logic        csr_wr;
  logic        win_hit;
  logic [15:0] period_reg;
  logic [15:0] tick_cnt_reg;
  logic        tick;
  logic        tick_irq_reg;
  logic        alert_irq_reg;
  logic        ack_reg;
  logic [15:0] rdata_reg;
  logic [15:0] mod_rdata_reg;
  logic [15:0] load_ptr_reg;
  logic [15:0] unload_ptr_reg;
  logic [15:0] shared_mem [0:32767];

  // Bus init acts as a full clear, just like power-up.
  assign hard_rst = rst_i | link.bus_init;
  assign new_req = link.bus_req & ~ack_reg;
  assign csr_wr = new_req & link.bus_csr & link.bus_we;
  // The bank field supplies address bits 21:16 to the comparator.
  assign win_hit = win_en_reg
                   & (link.bus_addr[21:16] == bank_reg);
  assign tick = (tick_cnt_reg >= period_reg - 16'h0001);
  // State reads zero while held in reset.
  assign csr_word = {db_mod_reg, tick_en_reg, bank_reg, db_host_reg,
                     irq_en_reg, win_en_reg, hold_reg,
                     hold_reg ? smh_pkg::ST_RESET : state_reg};

  // Host-writable fields; main reset and bus init load them all from CSR_RESET.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
    begin
      hold_reg <= smh_pkg::CSR_RESET[smh_pkg::HOLD_BIT];
      win_en_reg <= smh_pkg::CSR_RESET[smh_pkg::WIN_EN_BIT];
      irq_en_reg <= smh_pkg::CSR_RESET[smh_pkg::HOST_IRQ_EN_BIT];
      bank_reg <= smh_pkg::CSR_RESET[smh_pkg::BANK_LSB +: 6];
      tick_en_reg <= smh_pkg::CSR_RESET[smh_pkg::TICK_EN_BIT];
    end
    else if (csr_wr)
    begin
      hold_reg <= link.bus_wdata[smh_pkg::HOLD_BIT];
      win_en_reg <= link.bus_wdata[smh_pkg::WIN_EN_BIT];
      irq_en_reg <= link.bus_wdata[smh_pkg::HOST_IRQ_EN_BIT];
      bank_reg <= link.bus_wdata[smh_pkg::BANK_LSB +: 6];
      tick_en_reg <= link.bus_wdata[smh_pkg::TICK_EN_BIT];
    end
  end

  // Only firmware writes the state; a host write reaches it only by setting the hold bit, which forces ST_RESET.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst || hold_reg)
      state_reg <= smh_pkg::ST_RESET;
    else if (fw_state_wr_i)
      state_reg <= fw_state_i;
  end

  // Doorbell to module: host sets, processor acknowledge clears.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      db_mod_reg <= smh_pkg::CSR_RESET[smh_pkg::DB_MOD_BIT];
    else if (csr_wr && link.bus_wdata[smh_pkg::DB_MOD_BIT])
      db_mod_reg <= 1'b1;
    else if (module_alert_ack_i)
      db_mod_reg <= 1'b0;
  end

  // Doorbell to host: module sets, host write of one clears.
  // A set in the same cycle as a clear wins while hold is clear; with the hold bit set, module sets are dropped.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      db_host_reg <= smh_pkg::CSR_RESET[smh_pkg::DB_HOST_BIT];
    else if (host_alert_set_i && !hold_reg)
      db_host_reg <= 1'b1;
    else if (csr_wr && link.bus_wdata[smh_pkg::DB_HOST_BIT])
      db_host_reg <= 1'b0;
  end

  // Core resets follow power-up, bus init or the hold bit.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      core_rst_reg <= 1'b1;
    else
      core_rst_reg <= hold_reg;
  end

  assign cpu_reset_o = core_rst_reg;
  assign dsp_reset_o = core_rst_reg;
  assign line_reset_o = core_rst_reg;

  // Interval timer keeps running whatever the enable says.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      period_reg <= smh_pkg::TICK_CYCLES;
    else if (tick_period_wr_i && tick_period_i != 16'h0000)
      period_reg <= tick_period_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst || tick)
      tick_cnt_reg <= 16'h0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end

  // Pending timer interrupt drops once the host takes delivery.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      tick_irq_reg <= 1'b0;
    else if (tick && tick_en_reg)
      tick_irq_reg <= 1'b1;
    else if (link.tick_ack)
      tick_irq_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      alert_irq_reg <= 1'b0;
    else
      alert_irq_reg <= db_host_reg & irq_en_reg;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      module_alert_irq_o <= 1'b0;
    else
      module_alert_irq_o <= db_mod_reg & ~hold_reg;
  end

  assign link.tick_irq = tick_irq_reg;
  assign link.alert_irq = alert_irq_reg;

  // Host bus answer: control register always, memory only in window.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= new_req & (link.bus_csr | win_hit);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst)
      rdata_reg <= 16'h0000;
    // Writes leave the read data alone so it stands until the next read.
    else if (new_req && !link.bus_we && link.bus_csr)
      rdata_reg <= csr_word;
    else if (new_req && !link.bus_we && win_hit)
      rdata_reg <= shared_mem[link.bus_addr[15:1]];
  end

  assign link.bus_ack = ack_reg;
  assign link.bus_rdata = rdata_reg;

  // Lower half is the command ring, upper half the message ring.
  // Byte lanes are not split; every access is a whole word.
  always_ff @(posedge sys_clk_i)
  begin
    if (new_req && !link.bus_csr && link.bus_we && win_hit)
      shared_mem[link.bus_addr[15:1]] <= link.bus_wdata;
    if (mod_mem_we_i)
      shared_mem[mod_mem_addr_i] <= mod_mem_wdata_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    mod_rdata_reg <= shared_mem[mod_mem_addr_i];
  end

  assign mod_mem_rdata_o = mod_rdata_reg;

  // Private pointers sit outside the shared array.
  always_ff @(posedge sys_clk_i)
  begin
    if (hard_rst || core_rst_reg)
    begin
      load_ptr_reg <= smh_pkg::MSG_RING_BASE;
      unload_ptr_reg <= smh_pkg::CMD_RING_BASE;
    end
    else if (mod_ptr_wr_i && !mod_ptr_sel_i)
      load_ptr_reg <= mod_ptr_i;
    else if (mod_ptr_wr_i && mod_ptr_sel_i)
      unload_ptr_reg <= mod_ptr_i;
  end

  assign mod_load_ptr_o = load_ptr_reg;
  assign mod_unload_ptr_o = unload_ptr_reg;
endmodule

// ===== verilog/smh_pkg.sv
// Shared constants for the shared-memory host control and status link.
package smh_pkg;
  localparam int STATE_LSB = 0;
  localparam int HOLD_BIT = 4;
  localparam int WIN_EN_BIT = 5;
  localparam int HOST_IRQ_EN_BIT = 6;
  localparam int DB_HOST_BIT = 7;
  localparam int BANK_LSB = 8;
  localparam int TICK_EN_BIT = 14;
  localparam int DB_MOD_BIT = 15;
  localparam logic [15:0] CSR_RESET = 16'h0000;
  localparam logic [3:0] ST_RESET = 4'h0;
  localparam logic [3:0] ST_READY = 4'h1;
  localparam logic [3:0] ST_BROKEN = 4'h2;
  localparam logic [3:0] ST_PARITY = 4'h3;
  localparam logic [3:0] ST_TRAP = 4'h4;
  localparam logic [3:0] ST_BUG = 4'h5;
  localparam logic [3:0] ST_RING = 4'h6;
  localparam logic [3:0] ST_ROM = 4'h7;
  localparam logic [3:0] ST_LOW_BANK_RAM_FAULT = 4'h8;
  localparam logic [3:0] ST_HIGH_BANK_RAM_FAULT = 4'h9;
  localparam logic [3:0] ST_RAM_ADDRESSING_FAULT = 4'hA;
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 125000;
  localparam logic [15:0] TICK_CYCLES = 16'(TICK_NS / CLK_NS);
  localparam logic [15:0] CMD_RING_BASE = 16'h0000;
  localparam logic [15:0] MSG_RING_BASE = 16'h8000;
  localparam logic [6:0] RSVD_PAGE = 7'h7F;
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_LOAD_PTR = 3'h4;
  localparam logic [2:0] REG_UNLOAD_PTR = 3'h5;
  localparam logic [2:0] REG_TICKS = 3'h6;
  localparam logic [4:0] BUS_TIMEOUT = 5'h10;
  localparam logic [2:0] INIT_CYCLES = 3'h4;
endpackage

// ===== verilog/smh_link_if.sv
// Parallel bus link between the host controller and the add-in module.
`timescale 1ns/100ps
interface smh_link_if;
  logic        bus_req;
  logic        bus_we;
  logic        bus_csr;
  logic [21:0] bus_addr;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;
  logic        bus_ack;
  logic        bus_init;
  logic        tick_irq;
  logic        tick_ack;
  logic        alert_irq;
  modport dev (
    input  bus_req, bus_we, bus_csr, bus_addr, bus_wdata, bus_init, tick_ack,
    output bus_rdata, bus_ack, tick_irq, alert_irq
  );
  modport host (
    output bus_req, bus_we, bus_csr, bus_addr, bus_wdata, bus_init, tick_ack,
    input  bus_rdata, bus_ack, tick_irq, alert_irq
  );
endinterface

// ===== verilog/smh_host.sv
// Host end: Avalon-MM command registers driving the parallel bus link.
`timescale 1ns/100ps
module smh_host (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Device link
  smh_link_if.host         link
);
  typedef enum logic [1:0] {
    SMH_IDLE = 2'b00,
    SMH_WAIT = 2'b01,
    SMH_DONE = 2'b11
  } smh_bus_e;

  smh_bus_e    st_reg;
  logic        wait_reg;
  logic [31:0] rd_reg;
  logic        take;
  logic        cmd_wr;
  logic [21:0] addr_reg;
  logic [15:0] wdata_reg;
  logic        we_reg;
  logic        csr_reg;
  logic        no_ans_reg;
  logic        refused_reg;
  logic [15:0] bus_rd_reg;
  logic [4:0]  tmo_reg;
  logic [2:0]  init_cnt_reg;
  logic [15:0] load_ptr_reg;
  logic [15:0] unload_ptr_reg;
  logic [15:0] ticks_reg;
  logic        tack_reg;
  logic        rsvd_hit;

  assign take = (avs_read | avs_write) & ~wait_reg;
  assign cmd_wr = take & avs_write & (avs_address == smh_pkg::REG_CMD)
                  & avs_writedata[0] & (st_reg == SMH_IDLE);
  // Writes into the reserved tail of either ring are refused here.
  assign rsvd_hit = ~avs_writedata[2] & avs_writedata[1]
                    & (addr_reg[14:8] == smh_pkg::RSVD_PAGE);

  // One wait cycle, then the answer; waitrequest rises again after.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      wait_reg <= 1'b1;
    else
      wait_reg <= ~((avs_read | avs_write) & wait_reg);
  end

  assign avs_waitrequest = wait_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rd_reg <= 32'h00000000;
    else if (avs_read && wait_reg)
      unique case (avs_address)
        smh_pkg::REG_ADDR: rd_reg <= {10'h000, addr_reg};
        smh_pkg::REG_WDATA: rd_reg <= {16'h0000, wdata_reg};
        smh_pkg::REG_STATUS:
          rd_reg <= {bus_rd_reg, 11'h000, link.alert_irq, link.tick_irq,
                     refused_reg, no_ans_reg, st_reg != SMH_IDLE};
        smh_pkg::REG_LOAD_PTR: rd_reg <= {16'h0000, load_ptr_reg};
        smh_pkg::REG_UNLOAD_PTR: rd_reg <= {16'h0000, unload_ptr_reg};
        smh_pkg::REG_TICKS: rd_reg <= {16'h0000, ticks_reg};
        default: rd_reg <= 32'h00000000;
      endcase
  end

  assign avs_readdata = rd_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      addr_reg <= 22'h000000;
      wdata_reg <= 16'h0000;
    end
    else if (take && avs_write && avs_address == smh_pkg::REG_ADDR)
      addr_reg <= avs_writedata[21:0];
    else if (take && avs_write && avs_address == smh_pkg::REG_WDATA)
      wdata_reg <= avs_writedata[15:0];
  end

  // Host pointers start on the first command and message buffers.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      load_ptr_reg <= smh_pkg::CMD_RING_BASE;
      unload_ptr_reg <= smh_pkg::MSG_RING_BASE;
    end
    else if (take && avs_write && avs_address == smh_pkg::REG_LOAD_PTR)
      load_ptr_reg <= avs_writedata[15:0];
    else if (take && avs_write && avs_address == smh_pkg::REG_UNLOAD_PTR)
      unload_ptr_reg <= avs_writedata[15:0];
  end

  // Bus cycle sequencer; a memory cycle nobody answers times out.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= SMH_IDLE;
      we_reg <= 1'b0;
      csr_reg <= 1'b0;
      tmo_reg <= 5'h00;
      no_ans_reg <= 1'b0;
      refused_reg <= 1'b0;
      bus_rd_reg <= 16'h0000;
    end
    else
      unique case (st_reg)
        SMH_IDLE:
          if (cmd_wr && rsvd_hit)
          begin
            // A refusal is the whole result of this command.
            refused_reg <= 1'b1;
            no_ans_reg <= 1'b0;
          end
          else if (cmd_wr)
          begin
            st_reg <= SMH_WAIT;
            we_reg <= avs_writedata[1];
            csr_reg <= avs_writedata[2];
            tmo_reg <= 5'h00;
            no_ans_reg <= 1'b0;
            refused_reg <= 1'b0;
          end
        SMH_WAIT:
          if (link.bus_ack)
          begin
            st_reg <= SMH_DONE;
            bus_rd_reg <= link.bus_rdata;
          end
          else if (tmo_reg == smh_pkg::BUS_TIMEOUT)
          begin
            st_reg <= SMH_DONE;
            no_ans_reg <= 1'b1;
          end
          else
            tmo_reg <= tmo_reg + 5'h01;
        SMH_DONE:
          st_reg <= SMH_IDLE;
      endcase
  end

  assign link.bus_req = (st_reg == SMH_WAIT);
  assign link.bus_we = we_reg;
  assign link.bus_csr = csr_reg;
  assign link.bus_addr = addr_reg;
  assign link.bus_wdata = wdata_reg;

  // Bus init is stretched over several cycles for a clean clear.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      init_cnt_reg <= smh_pkg::INIT_CYCLES;
    else if (take && avs_write && avs_address == smh_pkg::REG_CMD
             && avs_writedata[3])
      init_cnt_reg <= smh_pkg::INIT_CYCLES;
    else if (init_cnt_reg != 3'h0)
      init_cnt_reg <= init_cnt_reg - 3'h1;
  end

  assign link.bus_init = (init_cnt_reg != 3'h0);

  // Taking delivery of a timer interrupt is the acknowledge cycle.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tack_reg <= 1'b0;
      ticks_reg <= 16'h0000;
    end
    else
    begin
      tack_reg <= link.tick_irq & ~tack_reg;
      if (link.tick_irq && !tack_reg)
        ticks_reg <= ticks_reg + 16'h0001;
    end
  end

  assign link.tick_ack = tack_reg;
endmodule

// ===== verif/smh_link_props.sv
// Concurrent checks on the link between the host and device ends.
`timescale 1ns/100ps
module smh_link_props (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // Link signals
  input wire logic        bus_req,
  input wire logic        bus_we,
  input wire logic        bus_csr,
  input wire logic [21:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic        bus_ack,
  input wire logic        bus_init,
  input wire logic        tick_irq,
  input wire logic        tick_ack,
  input wire logic        alert_irq
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] csr_reg;
  logic        take;
  logic        hit;
  assign take = bus_req && !bus_ack;
  assign hit  = csr_reg[5] && (bus_addr[21:16] == csr_reg[13:8]);
  // Only host-written bits are shadowed, so the doorbells are never used.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || bus_init)
      csr_reg <= 16'h0000;
    else if (take && bus_we && bus_csr)
      csr_reg <= bus_wdata;
  end
  a_ack_after_take: assert property (bus_ack |-> $past(take))
    else $error("Link acknowledge without a pending request.");
  a_window_answer: assert property (
    take && !bus_csr && hit && !csr_reg[4] |=> bus_ack)
    else $error("Access inside the window was not answered.");
  a_window_block: assert property (
    take && !bus_csr && !hit |=> !bus_ack)
    else $error("Access outside the window was answered.");
  a_init_quiet: assert property (
    bus_init |=> !bus_ack && !tick_irq && !alert_irq)
    else $error("Device still active during bus init.");
  a_init_length: assert property (
    $rose(bus_init) |-> bus_init [*4] ##1 !bus_init)
    else $error("Bus init pulse has the wrong length.");
  a_tick_enabled: assert property (
    $rose(tick_irq) |-> csr_reg[14] || $past(csr_reg[14]))
    else $error("Timer interrupt raised while disabled.");
  a_tick_withdraw: assert property (
    $rose(tick_irq) |-> ##[1:4] !tick_irq)
    else $error("Timer interrupt not withdrawn after delivery.");
  a_tick_ack_drop: assert property (tick_ack && tick_irq |=> !tick_irq)
    else $error("Timer interrupt stayed up after acknowledge.");
  a_alert_gated: assert property (alert_irq |-> $past(csr_reg[6]))
    else $error("Alert interrupt raised while its enable is clear.");
  a_rdata_hold: assert property (
    bus_rdata != $past(bus_rdata)
    |-> (bus_ack && !bus_we) || $past(bus_init))
    else $error("Link read data changed without a read answer.");
  c_window_hit: cover property (take && !bus_csr && hit ##1 bus_ack);
  c_window_miss: cover property (take && !bus_csr && !hit);
  c_tick: cover property ($rose(tick_irq));
  c_alert: cover property ($rose(alert_irq));
endmodule

// ===== verif/tb_top.sv
// Bench joining both link ends and checking them from their user sides.
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        st_wr = 1'h0;
  logic [3:0]  st_val = 4'h0;
  logic        ha_set = 1'h0;
  logic        ma_ack = 1'h0;
  logic        per_wr = 1'h0;
  logic [15:0] per_val = 16'h0;
  logic        mem_we = 1'h0;
  logic [14:0] mem_addr = 15'h0;
  logic [15:0] mem_wd = 16'h0;
  logic        ptr_wr = 1'h0;
  logic        ptr_sel = 1'h0;
  logic [15:0] ptr_val = 16'h0;
  logic        ma_irq, cpu_rst, dsp_rst, line_rst;
  logic [15:0] mem_rd, ld_ptr, ul_ptr;
  logic [31:0] q, t, cyc = 0, tick_cnt = 0, tick_gap = 0, n_ticks = 0;
  logic        tick_prev = 1'h0;
  int          error_cnt = 0;
  int          n_checks = 0;

  always #(smh_pkg::CLK_NS / 2) sys_clk_i = ~sys_clk_i;

  smh_link_if smh_link_if_inst ();
  smh_host smh_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(smh_link_if_inst));
  smh_device smh_device_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link(smh_link_if_inst), .fw_state_wr_i(st_wr), .fw_state_i(st_val),
    .host_alert_set_i(ha_set), .module_alert_ack_i(ma_ack),
    .tick_period_wr_i(per_wr), .tick_period_i(per_val),
    .module_alert_irq_o(ma_irq), .cpu_reset_o(cpu_rst),
    .dsp_reset_o(dsp_rst), .line_reset_o(line_rst),
    .mod_mem_addr_i(mem_addr), .mod_mem_we_i(mem_we),
    .mod_mem_wdata_i(mem_wd), .mod_mem_rdata_o(mem_rd),
    .mod_ptr_wr_i(ptr_wr), .mod_ptr_sel_i(ptr_sel), .mod_ptr_i(ptr_val),
    .mod_load_ptr_o(ld_ptr), .mod_unload_ptr_o(ul_ptr));
  smh_link_props smh_link_props_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus_req(smh_link_if_inst.bus_req), .bus_we(smh_link_if_inst.bus_we),
    .bus_csr(smh_link_if_inst.bus_csr), .bus_addr(smh_link_if_inst.bus_addr),
    .bus_wdata(smh_link_if_inst.bus_wdata),
    .bus_rdata(smh_link_if_inst.bus_rdata),
    .bus_ack(smh_link_if_inst.bus_ack), .bus_init(smh_link_if_inst.bus_init),
    .tick_irq(smh_link_if_inst.tick_irq),
    .tick_ack(smh_link_if_inst.tick_ack),
    .alert_irq(smh_link_if_inst.alert_irq));

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Ticks are watched on the falling edge so the flop update never races.
  always @(negedge sys_clk_i)
  begin
    cyc <= cyc + 32'h1;
    tick_cnt <= tick_cnt + 32'h1;
    tick_prev <= smh_link_if_inst.tick_irq;
    if (smh_link_if_inst.tick_irq === 1'h1 && tick_prev === 1'h0)
    begin
      tick_gap <= tick_cnt;
      tick_cnt <= 32'h1;
      n_ticks <= n_ticks + 32'h1;
    end
    if (cyc == 32'h0000EA60)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [2:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk_i);
    while (avs_waitrequest !== 1'h0)
      @(posedge sys_clk_i);
    r = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge sys_clk_i);
  endtask

  task automatic lnk(input logic [3:0] c, input logic [21:0] a,
                     input logic [15:0] d, output logic [31:0] s);
    av(1'h1, smh_pkg::REG_ADDR, {10'h0, a}, s);
    av(1'h1, smh_pkg::REG_WDATA, {16'h0, d}, s);
    av(1'h1, smh_pkg::REG_CMD, {28'h0, c}, s);
    s = 32'h1;
    while (s[0] !== 1'h0)
      av(1'h0, smh_pkg::REG_STATUS, 32'h0, s);
  endtask

  task automatic rd_link(input logic [3:0] c, input logic [21:0] a,
                         input logic [15:0] e);
    lnk(c, a, 16'h0, q);
    chk({16'h0, q[31:16]}, {16'h0, e});
  endtask

  task automatic stat(input int i, input logic e);
    av(1'h0, smh_pkg::REG_STATUS, 32'h0, q);
    chk({31'h0, q[i]}, {31'h0, e});
  endtask

  task automatic mod_rd(input logic [14:0] a, input logic [15:0] e);
    mem_addr <= a;
    repeat (2) @(negedge sys_clk_i);
    chk({16'h0, mem_rd}, {16'h0, e});
    @(posedge sys_clk_i);
  endtask

  task automatic wait_ticks(input logic [31:0] n);
    t = n_ticks;
    wait (n_ticks == t + n);
    @(posedge sys_clk_i);
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    repeat (8) @(posedge sys_clk_i);
    av(1'h0, smh_pkg::REG_LOAD_PTR, 32'h0, q);
    chk(q, 32'h0);
    av(1'h0, smh_pkg::REG_UNLOAD_PTR, 32'h0, q);
    chk(q, 32'h8000);
    av(1'h1, smh_pkg::REG_LOAD_PTR, 32'h40, q);
    av(1'h0, smh_pkg::REG_LOAD_PTR, 32'h0, q);
    chk(q, 32'h40);
    chk({ld_ptr, ul_ptr}, 32'h80000000);
    chk({29'h0, cpu_rst, dsp_rst, line_rst}, 32'h0);
    rd_link(4'h5, 22'h0, 16'h0);
    lnk(4'h3, 22'h0, 16'h1111, q);
    chk({30'h0, q[2:1]}, 32'h1);
    lnk(4'h7, 22'h0, 16'h1220, q);
    rd_link(4'h5, 22'h0, 16'h1220);
    lnk(4'h3, 22'h120010, 16'hA5C3, q);
    mod_rd(15'h0008, 16'hA5C3);
    lnk(4'h3, 22'h12FEFE, 16'h3C5A, q);
    mod_rd(15'h7F7F, 16'h3C5A);
    mem_addr <= 15'h4000;
    mem_wd <= 16'h5A3C;
    mem_we <= 1'h1;
    @(posedge sys_clk_i);
    mem_we <= 1'h0;
    @(posedge sys_clk_i);
    rd_link(4'h1, 22'h128000, 16'h5A3C);
    lnk(4'h1, 22'h130010, 16'h0, q);
    chk({30'h0, q[2:1]}, 32'h1);
    lnk(4'h3, 22'h127F00, 16'h1234, q);
    chk({30'h0, q[2:1]}, 32'h2);
    lnk(4'h7, 22'h0, 16'h9220, q);
    chk({31'h0, ma_irq}, 32'h1);
    rd_link(4'h5, 22'h0, 16'h9220);
    lnk(4'h7, 22'h0, 16'h1220, q);
    rd_link(4'h5, 22'h0, 16'h9220);
    ma_ack <= 1'h1;
    @(posedge sys_clk_i);
    ma_ack <= 1'h0;
    rd_link(4'h5, 22'h0, 16'h1220);
    chk({31'h0, ma_irq}, 32'h0);
    for (int s = 0; s < 11; s++)
    begin
      st_val <= 4'(s);
      st_wr <= 1'h1;
      @(posedge sys_clk_i);
      st_wr <= 1'h0;
      rd_link(4'h5, 22'h0, {12'h122, 4'(s)});
    end
    lnk(4'h7, 22'h0, 16'h126F, q);
    ha_set <= 1'h1;
    @(posedge sys_clk_i);
    ha_set <= 1'h0;
    rd_link(4'h5, 22'h0, 16'h12EA);
    stat(4, 1'h1);
    lnk(4'h7, 22'h0, 16'h1260, q);
    rd_link(4'h5, 22'h0, 16'h12EA);
    lnk(4'h7, 22'h0, 16'h12E0, q);
    rd_link(4'h5, 22'h0, 16'h126A);
    stat(4, 1'h0);
    lnk(4'h7, 22'h0, 16'h5220, q);
    rd_link(4'h5, 22'h0, 16'h522A);
    wait_ticks(2);
    chk(tick_gap, {16'h0, smh_pkg::TICK_CYCLES});
    av(1'h0, smh_pkg::REG_TICKS, 32'h0, q);
    chk(q, n_ticks);
    per_val <= 16'h0028;
    per_wr <= 1'h1;
    @(posedge sys_clk_i);
    per_wr <= 1'h0;
    wait_ticks(3);
    chk(tick_gap, 32'h28);
    lnk(4'h7, 22'h0, 16'h1220, q);
    t = n_ticks;
    repeat (120) @(posedge sys_clk_i);
    chk(n_ticks, t);
    ptr_val <= 16'h8040;
    ptr_wr <= 1'h1;
    @(posedge sys_clk_i);
    ptr_sel <= 1'h1;
    ptr_val <= 16'h0040;
    @(posedge sys_clk_i);
    ptr_wr <= 1'h0;
    ptr_sel <= 1'h0;
    @(negedge sys_clk_i);
    chk({ld_ptr, ul_ptr}, 32'h80400040);
    @(posedge sys_clk_i);
    lnk(4'h7, 22'h0, 16'h1230, q);
    chk({29'h0, cpu_rst, dsp_rst, line_rst}, 32'h7);
    rd_link(4'h5, 22'h0, 16'h1230);
    chk({ld_ptr, ul_ptr}, 32'h80000000);
    lnk(4'h7, 22'h0, 16'h1220, q);
    chk({29'h0, cpu_rst, dsp_rst, line_rst}, 32'h0);
    rd_link(4'h5, 22'h0, 16'h1220);
    av(1'h1, smh_pkg::REG_CMD, 32'h8, q);
    wait (smh_link_if_inst.bus_init === 1'h1);
    @(negedge sys_clk_i);
    chk({29'h0, cpu_rst, dsp_rst, line_rst}, 32'h7);
    wait (smh_link_if_inst.bus_init === 1'h0);
    repeat (2) @(posedge sys_clk_i);
    rd_link(4'h5, 22'h0, 16'h0);
    tally_and_finish();
  end
endmodule
